// ---- vrl_map.svh ----
// register offsets, field positions, reset values and ladder arithmetic of the reference ladder control
`ifndef VRL_MAP_SVH
`define VRL_MAP_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define VRL_OFF_CTRL        12'h000
`define VRL_OFF_STATUS      12'h004
`define VRL_ADDR_W          12

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define VRL_CTRL_W          8
`define VRL_CTRL_RESET      8'h00
`define VRL_BIT_POWER_ON    7
`define VRL_BIT_PIN_DRIVE   6
`define VRL_BIT_RANGE_SEL   5
`define VRL_BIT_SOURCE_SEL  4
`define VRL_TAP_MSB         3
`define VRL_TAP_LSB         0

// ---------------------------------------------------------------
// status register fields
// ---------------------------------------------------------------
`define VRL_STS_LEVEL_LSB   0
`define VRL_STS_LEVEL_MSB   6
`define VRL_STS_DIR         8
`define VRL_STS_PIN_CONN    9
`define VRL_STS_CMP_REF     10
`define VRL_STS_PIN_OVR     11

// ---------------------------------------------------------------
// ladder arithmetic, level expressed in 96ths of the source span
// ---------------------------------------------------------------
`define VRL_LEVEL_W         7
`define VRL_LOW_STEP        7'h04
`define VRL_HIGH_STEP       7'h03
`define VRL_HIGH_BASE       7'h18
`define VRL_CMP_MODE_REF    3'h6

`endif

// ---- vrl_pkg.sv ----
// types shared by the reference ladder control block
package vrl_pkg;

	typedef logic [31:0] vrl_word_t;

	typedef struct packed
	{
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} vrl_apb_req_s;

	typedef struct packed
	{
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} vrl_apb_rsp_s;

	typedef struct packed
	{
		logic        power_on;
		logic        source_ext;
		logic        range_low;
		logic [15:0] tap_onehot;
		logic [6:0]  level_96ths;
	} vrl_ladder_s;

	typedef enum logic
	{
		VRL_RANGE_HIGH,
		VRL_RANGE_LOW
	} vrl_range_e;

endpackage

// ---- vrl_tap_decode.sv ----
// tap switch decode and nominal level of the resistor ladder
`timescale 1ns/10ps
`include "vrl_map.svh"

module vrl_tap_decode
#(
	parameter int TAPS = 16
)
(
	input  wire logic                       i_range_low,
	input  wire logic [$clog2(TAPS)-1:0]    i_tap_code,
	output logic      [TAPS-1:0]            o_tap_onehot,
	output logic      [`VRL_LEVEL_W-1:0]    o_level_96ths
);
	import vrl_pkg::*;

	// ---------------------------------------------------------------
	// one switch closed per tap code
	// ---------------------------------------------------------------
	wire [`VRL_LEVEL_W-1:0] code_ext = `VRL_LEVEL_W'(i_tap_code);
	wire [`VRL_LEVEL_W-1:0] low_lvl  = `VRL_LEVEL_W'(code_ext * `VRL_LOW_STEP);
	wire [`VRL_LEVEL_W-1:0] high_lvl = `VRL_LEVEL_W'(`VRL_HIGH_BASE
	                                 + code_ext * `VRL_HIGH_STEP);

	assign o_tap_onehot  = TAPS'(1) << i_tap_code;
	// low range: code/24 of span; high range: span/4 + code/32 of span
	assign o_level_96ths = i_range_low ? low_lvl : high_lvl;

endmodule

// ---- vrl_top.sv ----
// apb controlled 16-tap reference ladder: control register, switches, pin override
`timescale 1ns/10ps
`include "vrl_map.svh"

// How it works
// - power-on bit seven high powers the ladder, low powers it down.
// - pin-drive bit six, with the direction bit set, routes the reference onto the shared pin, else disconnects.
// - range bit five: one picks low range span/24 steps, zero high range.
// - source bit four: one picks external reference pins, zero supply rails.
// - tap code three to zero picks level code/24, or span/4 plus code/32.
// - reset clears the whole control register: off, disconnected, high range.
// - waking from sleep leaves every control bit unchanged.
// - pin-drive overrides the port direction bit of the shared pin.
// - reference reaches the pin when direction bit and pin-drive are both set.
// - the reference works whatever the comparator configuration is.
// - comparators take the reference only in mode 110, on both positive inputs.
module vrl_top
#(
	parameter int TAPS = 16
)
(
	input  wire logic                  i_core_clk,
	input  wire logic                  i_arst_n,
	input  wire vrl_pkg::vrl_apb_req_s i_apb,
	output vrl_pkg::vrl_apb_rsp_s      o_apb,
	input  wire logic                  i_port_a_direction,
	input  wire logic [2:0]            i_comparator_mode_field,
	input  wire logic                  i_sleep,
	output vrl_pkg::vrl_ladder_s       o_ladder,
	output logic                       o_shared_port_pin_connect,
	output logic                       o_shared_port_pin_dig_oe_n,
	output logic                       o_cmp_ref_select,
	output logic                       o_cmp_pos_ref_en,
	output logic                       o_sleep_ladder_on
);
	import vrl_pkg::*;

	// ---------------------------------------------------------------
	// control register state
	// ---------------------------------------------------------------
	logic [`VRL_CTRL_W-1:0] voltage_reference_control_q;
	logic [`VRL_CTRL_W-1:0] voltage_reference_control_d;
	logic [31:0]            prdata_q;
	logic [31:0]            prdata_d;
	logic                   pslverr_q;
	logic                   pslverr_d;

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	wire setup_ph   = i_apb.psel & ~i_apb.penable;
	wire access_ph  = i_apb.psel & i_apb.penable;
	wire hit_ctrl   = (i_apb.paddr == `VRL_OFF_CTRL);
	wire hit_status = (i_apb.paddr == `VRL_OFF_STATUS);
	wire hit_any    = hit_ctrl | hit_status;
	wire wr_ctrl    = access_ph & i_apb.pwrite & hit_ctrl & i_apb.pstrb[0];
	wire wr_status  = setup_ph & i_apb.pwrite & hit_status;

	// ---------------------------------------------------------------
	// control fields
	// ---------------------------------------------------------------
	wire       ref_power_on   = voltage_reference_control_q[`VRL_BIT_POWER_ON];
	wire       ref_pin_drive  = voltage_reference_control_q[`VRL_BIT_PIN_DRIVE];
	wire       ref_range_sel  = voltage_reference_control_q[`VRL_BIT_RANGE_SEL];
	wire       ref_source_sel = voltage_reference_control_q[`VRL_BIT_SOURCE_SEL];
	wire [3:0] ref_tap_code   = voltage_reference_control_q[`VRL_TAP_MSB:`VRL_TAP_LSB];

	vrl_range_e range_mode;
	assign range_mode = ref_range_sel ? VRL_RANGE_LOW : VRL_RANGE_HIGH;

	// ---------------------------------------------------------------
	// ladder switch decode
	// ---------------------------------------------------------------
	logic [TAPS-1:0]         tap_onehot;
	logic [`VRL_LEVEL_W-1:0] level_96ths;

	vrl_tap_decode
	#(
		.TAPS (TAPS)
	)
	u_tap_decode
	(
		.i_range_low   (range_mode == VRL_RANGE_LOW),
		.i_tap_code    (ref_tap_code),
		.o_tap_onehot  (tap_onehot),
		.o_level_96ths (level_96ths)
	);

	// ---------------------------------------------------------------
	// ladder outputs follow the register with no added stage
	// ---------------------------------------------------------------
	always_comb
	begin
		o_ladder             = '0;
		o_ladder.power_on    = ref_power_on;
		o_ladder.source_ext  = ref_source_sel;
		o_ladder.range_low   = (range_mode == VRL_RANGE_LOW);
		o_ladder.tap_onehot  = 16'(tap_onehot);
		o_ladder.level_96ths = level_96ths;
	end

	// ---------------------------------------------------------------
	// shared pin: analog connect and digital driver override
	// ---------------------------------------------------------------
	// analog path closes only with both direction and pin-drive set
	wire pin_connect = ref_pin_drive & i_port_a_direction;
	assign o_shared_port_pin_connect = pin_connect;
	// pin-drive forces the digital output driver off whatever the direction says
	assign o_shared_port_pin_dig_oe_n = ref_pin_drive | i_port_a_direction;

	// ---------------------------------------------------------------
	// comparator feed
	// ---------------------------------------------------------------
	// the ladder itself never looks at the comparator mode
	wire cmp_uses_ref = (i_comparator_mode_field == `VRL_CMP_MODE_REF);
	assign o_cmp_ref_select = cmp_uses_ref;
	assign o_cmp_pos_ref_en = cmp_uses_ref & ref_power_on;

	// ---------------------------------------------------------------
	// sleep indication: ladder left on across sleep costs current
	// ---------------------------------------------------------------
	assign o_sleep_ladder_on = i_sleep & ref_power_on;

	// ---------------------------------------------------------------
	// register next value
	// ---------------------------------------------------------------
	// sleep and wake have no path into the register
	always_comb
	begin
		voltage_reference_control_d = voltage_reference_control_q;
		if (wr_ctrl)
		begin
			voltage_reference_control_d = i_apb.pwdata[`VRL_CTRL_W-1:0];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			voltage_reference_control_q <= `VRL_CTRL_RESET;
		end
		else
		begin
			voltage_reference_control_q <= voltage_reference_control_d;
		end
	end

	// ---------------------------------------------------------------
	// status word
	// ---------------------------------------------------------------
	logic [31:0] status_word;

	always_comb
	begin
		status_word = '0;
		status_word[`VRL_STS_LEVEL_MSB:`VRL_STS_LEVEL_LSB] = level_96ths;
		status_word[`VRL_STS_DIR]      = i_port_a_direction;
		status_word[`VRL_STS_PIN_CONN] = pin_connect;
		status_word[`VRL_STS_CMP_REF]  = cmp_uses_ref;
		status_word[`VRL_STS_PIN_OVR]  = ref_pin_drive;
	end

	// ---------------------------------------------------------------
	// read data and error, prepared in setup so access answers at once
	// ---------------------------------------------------------------
	wire [31:0] ctrl_word = {24'h000000, voltage_reference_control_q};
	wire [31:0] rd_mux    = hit_ctrl   ? ctrl_word
	                      : hit_status ? status_word
	                      : 32'h00000000;

	always_comb
	begin
		prdata_d  = prdata_q;
		pslverr_d = pslverr_q;
		if (setup_ph)
		begin
			prdata_d  = i_apb.pwrite ? 32'h00000000 : rd_mux;
			pslverr_d = ~hit_any | wr_status;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end
		else
		begin
			prdata_q  <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	// ---------------------------------------------------------------
	// apb answer: zero wait states
	// ---------------------------------------------------------------
	always_comb
	begin
		o_apb         = '0;
		o_apb.pready  = 1'b1;
		o_apb.pslverr = access_ph & pslverr_q;
		o_apb.prdata  = access_ph ? prdata_q : 32'h00000000;
	end

endmodule

// ---- vrl_pin_model.sv ----
// pad model of the shared port pin seen from outside the block
`timescale 1ns/10ps
module vrl_pin_model
(
	input  wire logic       i_core_clk,
	input  wire logic       i_connect,
	input  wire logic       i_dig_oe_n,
	input  wire logic       i_dig_out,
	input  wire logic [6:0] i_level,
	output logic      [6:0] o_pin
);
	logic [6:0] last_q = 7'h00;
	// an undriven pin shows the inverse of its last value
	always @(posedge i_core_clk)
		last_q <= o_pin;
	assign o_pin = i_connect ? i_level : (!i_dig_oe_n ? {7{i_dig_out}} : ~last_q);
endmodule

// ---- vrl_top_assertions.sv ----
// concurrent checks on the ports of the reference ladder control
`timescale 1ns/10ps
module vrl_top_chk
#(
	parameter int TAPS = 16
)
(
	input wire logic                  i_core_clk,
	input wire logic                  i_arst_n,
	input wire vrl_pkg::vrl_apb_req_s i_apb,
	input wire vrl_pkg::vrl_apb_rsp_s o_apb,
	input wire logic                  i_port_a_direction,
	input wire logic [2:0]            i_comparator_mode_field,
	input wire logic                  i_sleep,
	input wire vrl_pkg::vrl_ladder_s  o_ladder,
	input wire logic                  o_shared_port_pin_connect,
	input wire logic                  o_shared_port_pin_dig_oe_n,
	input wire logic                  o_cmp_ref_select,
	input wire logic                  o_cmp_pos_ref_en,
	input wire logic                  o_sleep_ladder_on
);
	import vrl_pkg::*;
	logic       wr;
	logic [3:0] code_q;
	logic       pd_q;
	assign wr = i_apb.psel & i_apb.penable & i_apb.pwrite & i_apb.pstrb[0] & (i_apb.paddr == 12'h000);
	always_ff @(posedge i_core_clk or negedge i_arst_n)
		if (!i_arst_n)
			{pd_q, code_q} <= 5'h00;
		else if (wr)
			{pd_q, code_q} <= {i_apb.pwdata[6], i_apb.pwdata[3:0]};
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	pwr_follow_a: assert property (wr |=> o_ladder.power_on == $past(i_apb.pwdata[7]))
		else $error("power bit not applied");
	src_sel_a: assert property (wr |=> o_ladder.source_ext == $past(i_apb.pwdata[4]))
		else $error("source bit not applied");
	range_sel_a: assert property (wr |=> o_ladder.range_low == $past(i_apb.pwdata[5]))
		else $error("range bit not applied");
	tap_sel_a: assert property (wr |=> o_ladder.tap_onehot == 16'h0001 << $past(i_apb.pwdata[3:0]))
		else $error("tap select wrong");
	level_calc_a: assert property (o_ladder.level_96ths == (o_ladder.range_low ? {1'b0, code_q, 2'b00} : 7'h18 + 7'(code_q) * 7'h03))
		else $error("level wrong");
	pin_conn_a: assert property (o_shared_port_pin_connect == (pd_q && i_port_a_direction))
		else $error("pin connect wrong");
	pin_ovr_a: assert property (pd_q |-> o_shared_port_pin_dig_oe_n)
		else $error("digital driver not overridden");
	cmp_mode_a: assert property (o_cmp_ref_select == (i_comparator_mode_field == 3'h6) && o_cmp_pos_ref_en == (o_cmp_ref_select && o_ladder.power_on))
		else $error("comparator reference wrong");
	sleep_hold_a: assert property (i_sleep && !wr |=> $stable(o_ladder))
		else $error("ladder changed in sleep");
	sleep_warn_a: assert property (o_sleep_ladder_on == (i_sleep && o_ladder.power_on))
		else $error("sleep warning wrong");
	rst_clear_a: assert property (!$past(i_arst_n) |-> !o_ladder.power_on && !o_ladder.range_low && o_ladder.tap_onehot == 16'h0001)
		else $error("reset state wrong");
	cover property (wr);
	cover property (o_shared_port_pin_connect);
	cover property (o_cmp_pos_ref_en);
endmodule
bind vrl_top vrl_top_chk #(.TAPS(TAPS)) vrl_top_chk_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
	.i_apb(i_apb), .o_apb(o_apb), .i_port_a_direction(i_port_a_direction),
	.i_comparator_mode_field(i_comparator_mode_field), .i_sleep(i_sleep), .o_ladder(o_ladder),
	.o_shared_port_pin_connect(o_shared_port_pin_connect),
	.o_shared_port_pin_dig_oe_n(o_shared_port_pin_dig_oe_n), .o_cmp_ref_select(o_cmp_ref_select),
	.o_cmp_pos_ref_en(o_cmp_pos_ref_en), .o_sleep_ladder_on(o_sleep_ladder_on));

// ---- vrl_top_bench.sv ----
// self-checking bench of the reference ladder control
`timescale 1ns/10ps
module vrl_top_bench;
	import vrl_pkg::*;
	logic clk, rst_n, dir, sleep, err, conn, oe_n, csel, cpos, slon;
	logic [2:0] mode;
	logic [6:0] pin;
	logic [7:0] v;
	logic [31:0] seed, rd, r;
	int bad_count, compares;
	vrl_apb_req_s req;
	vrl_apb_rsp_s rsp;
	vrl_ladder_s lad;
	vrl_top vrl_top_i (.i_core_clk(clk), .i_arst_n(rst_n), .i_apb(req), .o_apb(rsp),
		.i_port_a_direction(dir), .i_comparator_mode_field(mode), .i_sleep(sleep),
		.o_ladder(lad), .o_shared_port_pin_connect(conn), .o_shared_port_pin_dig_oe_n(oe_n),
		.o_cmp_ref_select(csel), .o_cmp_pos_ref_en(cpos), .o_sleep_ladder_on(slon));
	vrl_pin_model vrl_pin_model_i (.i_core_clk(clk), .i_connect(conn), .i_dig_oe_n(oe_n),
		.i_dig_out(r[0]), .i_level(lad.level_96ths), .o_pin(pin));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [6:0] exp_level(input logic [7:0] c);
		return c[5] ? {1'b0, c[3:0], 2'b00} : 7'h18 + 7'(c[3:0]) * 7'h03;
	endfunction
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one apb transfer, request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
		@(posedge clk);
		req.penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge clk);
			if (rsp.pready === 1'b1)
				break;
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		if (n == 16)
		begin
			bad_count++;
			print_verdict();
		end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial
	begin
		bad_count = 0;
		compares = 0;
		seed = 32'hcb1073bd;
		r = 32'h0;
		{rst_n, dir, sleep, req} = '0;
		mode = 3'h7;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk_w(rd, 32'h0);
		chk_w(32'(lad), 32'({3'h0, 16'h0001, 7'h18}));
		$display("test reset done");
		for (int i = 0; i < 48; i++)
		begin
			r = rnd();
			v = (i == 0) ? 8'hdf : (i == 1) ? 8'h6f : r[7:0];
			dir <= (i == 0) ? 1'b1 : r[8];
			mode <= (i == 0) ? 3'h6 : r[11:9];
			apb(1'b1, 12'h000, {r[31:8], v}, 4'hf);
			#1;
			chk_w(32'(lad.power_on), 32'(v[7]));
			chk_w(32'(lad.range_low), 32'(v[5]));
			chk_w(32'(lad.source_ext), 32'(v[4]));
			chk_w(32'(lad.tap_onehot), 32'h1 << v[3:0]);
			chk_w(32'(lad.level_96ths), 32'(exp_level(v)));
			chk_w(32'(conn), 32'(v[6] & dir));
			chk_w(32'(oe_n), 32'(v[6] | dir));
			chk_w(32'(cpos), 32'(mode == 3'h6 && v[7]));
			chk_w(32'(csel), 32'(mode == 3'h6));
			if (conn === 1'b1)
				chk_w(32'(pin), 32'(exp_level(v)));
			apb(1'b0, 12'h000, 32'h0, 4'h0);
			chk_w(rd, {24'h0, v});
		end
		$display("test random done");
		@(posedge clk);
		sleep <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		chk_w(32'(slon), 32'(v[7]));
		@(posedge clk);
		sleep <= 1'b0;
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk_w(rd, {24'h0, v});
		// software powers the ladder down before sleeping
		v = v & 8'h7f;
		apb(1'b1, 12'h000, {24'h0, v}, 4'hf);
		sleep <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk_w(32'(slon), 32'h0);
		chk_w(32'(lad.power_on), 32'h0);
		@(posedge clk);
		sleep <= 1'b0;
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk_w(rd, {24'h0, v});
		$display("test sleep done");
		apb(1'b1, 12'h004, 32'hff, 4'hf);
		chk_w(32'(err), 32'h1);
		apb(1'b0, 12'h100, 32'h0, 4'h0);
		chk_w({31'h0, err} | rd, 32'h1);
		apb(1'b1, 12'h000, ~{24'h0, v}, 4'h0);
		apb(1'b0, 12'h000, 32'h0, 4'h0);
		chk_w(rd, {24'h0, v});
		$display("test refusal done");
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk_w(32'(lad), 32'({3'h0, 16'h0001, 7'h18}));
		chk_w(32'(conn), 32'h0);
		repeat (2) @(posedge clk);
		#1;
		chk_w(32'(lad), 32'({3'h0, 16'h0001, 7'h18}));
		$display("test second reset done");
		print_verdict();
	end
endmodule
